/* File: verilog/scd_pkg.sv */
// Package for the system clock divider and sleep gating block.
// Assumes a single source clock core_clk and an 8-bit I/O register port.
package scd_pkg;

  localparam logic [7:0] IO_ADDR_TRIM   = 8'h31;
  localparam logic [7:0] IO_ADDR_DIVCTL = 8'h3c;
  localparam logic [7:0] DATA_OFFSET    = 8'h20;
  localparam logic [7:0] IO_SPACE_TOP   = 8'h3f;

  localparam int         DIV_EN_BIT     = 7;
  localparam logic [7:0] TRIM_RESET     = 8'h00;
  localparam logic [7:0] DIVCTL_RESET   = 8'h00;
  localparam logic [7:0] DIV_BASE       = 8'h81;
  localparam logic [7:0] DIV_MIN        = 8'h02;

  localparam int         WAKE_HALT_CYC  = 4;

  localparam int         STARTUP_W      = 16;

  typedef enum logic [2:0] {
    SCD_SLP_IDLE     = 3'b000,
    SCD_SLP_ADCNR    = 3'b001,
    SCD_SLP_PWRDOWN  = 3'b010,
    SCD_SLP_PWRSAVE  = 3'b011,
    SCD_SLP_RSV4     = 3'b100,
    SCD_SLP_RSV5     = 3'b101,
    SCD_SLP_STANDBY  = 3'b110,
    SCD_SLP_EXTSTBY  = 3'b111
  } scd_sleep_e;

  // Clock enables per domain, also main source and async clock
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic conv;
    logic async;
    logic main_src;
  } scd_gate_s;

  // Wake-up sources
  typedef struct packed {
    logic ext_irq;
    logic addr_match;
    logic timer0;
    logic mem_ready;
    logic conv_done;
    logic other_io;
  } scd_wake_s;

endpackage : scd_pkg

/* File: verilog/scd_divider.sv */
// Glitch-free integer clock divider producing a one-cycle enable.
// Assumes the factor is stable while enable is high.
`timescale 1ns/1ps
module scd_divider (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       enable,
  input  wire logic [7:0] factor,
  output logic            tick
);
  logic [7:0] count;

  // Counting restarts on enable so every phase is whole source cycles
  always_ff @(posedge core_clk) begin
    if (reset || !enable) begin
      count <= 8'h00;
      tick  <= 1'b0;
    end else if (count >= factor - 8'h01) begin
      count <= 8'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 8'h01;
      tick  <= 1'b0;
    end
  end

endmodule : scd_divider

/* File: verilog/scd_clock_ctrl.sv */
// Clock divider control, oscillator trim register and sleep gating.
// Assumes CPU register port signals are synchronous to core_clk.
`timescale 1ns/1ps
module scd_clock_ctrl (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic [7:0]              reg_addr,
  input  wire logic                    reg_data_space,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  input  wire logic [7:0]              reg_wdata,
  output logic      [7:0]              reg_rdata,
  input  wire logic [7:0]              cal_byte_1mhz,
  input  wire logic                    sleep_req,
  input  wire logic [2:0]              sleep_select_field,
  input  wire logic                    timer_async_select,
  input  wire logic                    crystal_selected,
  input  wire logic                    startup_done,
  input  wire scd_pkg::scd_wake_s      wake_raw,
  output scd_pkg::scd_gate_s           gate,
  output logic                         sys_tick,
  output logic                         cpu_run,
  output logic                         wake_irq,
  output logic      [7:0]              trim_value_bits
);
  typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_START, ST_HALT} scd_st_e;

  logic [7:0]         divide_control;
  logic               div_tick;
  logic               cal_pending;
  logic               wake_any;
  logic [2:0]         halt_cnt;
  scd_st_e            state;
  scd_pkg::scd_sleep_e mode;
  scd_pkg::scd_gate_s  next_gate;
  scd_pkg::scd_wake_s  wake_mask;
  scd_pkg::scd_wake_s  wake_meta;
  scd_pkg::scd_wake_s  wake_sync;

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic ds,
                               input logic [7:0] io);
    hit = ds ? (a == io + scd_pkg::DATA_OFFSET) : (a == io);
  endfunction : hit

  wire wr_trim = reg_wr && hit(reg_addr, reg_data_space,
                               scd_pkg::IO_ADDR_TRIM);
  wire wr_div  = reg_wr && hit(reg_addr, reg_data_space,
                               scd_pkg::IO_ADDR_DIVCTL);
  wire div_en  = divide_control[scd_pkg::DIV_EN_BIT];
  wire new_en  = reg_wdata[scd_pkg::DIV_EN_BIT];

  // Factor kept 8-bit wide: 129 - d gives 2..129
  wire [7:0] factor = scd_pkg::DIV_BASE - {1'b0, divide_control[6:0]};

  always_ff @(posedge core_clk) begin
    if (reset) begin
      divide_control <= scd_pkg::DIVCTL_RESET;
    end else if (wr_div) begin
      if (new_en && !div_en) begin
        divide_control <= reg_wdata;
      end else if (!new_en) begin
        divide_control <= {1'b0, divide_control[6:0]};
      end
    end
  end

  // Trim reset value, then the calibration byte is loaded after release
  always_ff @(posedge core_clk) begin
    if (reset) begin
      trim_value_bits <= scd_pkg::TRIM_RESET;
      cal_pending     <= 1'b1;
    end else if (cal_pending) begin
      trim_value_bits <= cal_byte_1mhz;
      cal_pending     <= 1'b0;
    end else if (wr_trim) begin
      trim_value_bits <= reg_wdata;
    end
  end

  scd_divider u_div (
    .core_clk (core_clk),
    .reset    (reset),
    .enable   (div_en),
    .factor   (factor),
    .tick     (div_tick)
  );

  // Enable-based division cannot glitch: each phase is whole cycles
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sys_tick <= 1'b0;
    end else begin
      sys_tick <= div_en ? div_tick : 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (hit(reg_addr, reg_data_space, scd_pkg::IO_ADDR_TRIM)) begin
        reg_rdata <= trim_value_bits;
      end else if (hit(reg_addr, reg_data_space,
                       scd_pkg::IO_ADDR_DIVCTL)) begin
        reg_rdata <= divide_control;
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  assign mode = scd_pkg::scd_sleep_e'(sleep_select_field);

  // Gating and wake mask per mode; reserved codes act as idle
  always_comb begin
    next_gate = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, conv: 1'b1,
                  async: 1'b1, main_src: 1'b1};
    wake_mask = '1;
    if (state != ST_RUN) begin
      unique case (mode)
        scd_pkg::SCD_SLP_ADCNR: begin
          next_gate = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, conv: 1'b1,
                        async: 1'b1, main_src: 1'b1};
          wake_mask = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        end
        scd_pkg::SCD_SLP_PWRDOWN: begin
          next_gate = '0;
          wake_mask = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        end
        scd_pkg::SCD_SLP_STANDBY: begin
          next_gate = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, conv: 1'b0,
                        async: 1'b0, main_src: crystal_selected};
          wake_mask = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        end
        scd_pkg::SCD_SLP_PWRSAVE, scd_pkg::SCD_SLP_EXTSTBY: begin
          next_gate = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, conv: 1'b0,
                        async: timer_async_select,
                        main_src: mode == scd_pkg::SCD_SLP_EXTSTBY
                                  && crystal_selected};
          wake_mask = '{1'b1, 1'b1, timer_async_select,
                        1'b0, 1'b0, 1'b0};
        end
        default: begin
          next_gate = '{cpu: 1'b0, flash: 1'b0, io: 1'b1, conv: 1'b1,
                        async: 1'b1, main_src: 1'b1};
          wake_mask = '1;
        end
      endcase
    end
  end

  // Wake lines come from pins and the async timer, so two flops first
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wake_meta <= '0;
      wake_sync <= '0;
    end else begin
      wake_meta <= wake_raw;
      wake_sync <= wake_meta;
    end
  end

  assign wake_any = |(wake_sync & wake_mask);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state    <= ST_RUN;
      halt_cnt <= 3'd0;
    end else begin
      unique case (state)
        ST_RUN:   if (sleep_req) state <= ST_SLEEP;
        ST_SLEEP: if (wake_any) state <= ST_START;
        ST_START: if (startup_done) begin
          state    <= ST_HALT;
          halt_cnt <= 3'd0;
        end
        ST_HALT: begin
          halt_cnt <= halt_cnt + 3'd1;
          if (halt_cnt == 3'(scd_pkg::WAKE_HALT_CYC - 1)) begin
            state <= ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      gate     <= '1;
      cpu_run  <= 1'b1;
      wake_irq <= 1'b0;
    end else begin
      gate     <= (state == ST_SLEEP) ? next_gate : '1;
      cpu_run  <= (state == ST_RUN) && !sleep_req;
      wake_irq <= (state == ST_HALT)
                  && halt_cnt == 3'(scd_pkg::WAKE_HALT_CYC - 1);
    end
  end

  a_div_capture: assert property (@(posedge core_clk) disable iff (reset)
    wr_div && new_en && !div_en |=> divide_control == $past(reg_wdata))
    else $error("divide field not captured");
  a_div_locked: assert property (@(posedge core_clk) disable iff (reset)
    div_en && !(wr_div && !new_en) |=> $stable(divide_control[6:0]))
    else $error("divide field changed while enabled");
  a_div_reject: assert property (@(posedge core_clk) disable iff (reset)
    wr_div && !new_en |=> divide_control[6:0] == $past(divide_control[6:0]))
    else $error("rejected field stored");
  a_div_range: assert property (@(posedge core_clk) disable iff (reset)
    factor >= scd_pkg::DIV_MIN && factor <= scd_pkg::DIV_BASE)
    else $error("factor out of range");
  a_tick_period: assert property (@(posedge core_clk) disable iff (reset)
    div_en && div_tick && $stable(factor) && factor > 8'h02
    |=> !div_tick)
    else $error("divided tick too close");
  a_undiv_run: assert property (@(posedge core_clk) disable iff (reset)
    !div_en |=> sys_tick)
    else $error("undivided clock gated");
  a_trim_load: assert property (@(posedge core_clk)
    $fell(reset) |=> trim_value_bits == $past(cal_byte_1mhz))
    else $error("calibration not loaded");
  a_pwrdown_gate: assert property (@(posedge core_clk) disable iff (reset)
    state == ST_SLEEP && mode == scd_pkg::SCD_SLP_PWRDOWN |=> gate == '0)
    else $error("power-down left a clock on");
  a_idle_gate: assert property (@(posedge core_clk) disable iff (reset)
    state == ST_SLEEP && mode == scd_pkg::SCD_SLP_IDLE
    |=> !gate.cpu && gate.io)
    else $error("idle gating wrong");
  a_wake_halt: assert property (@(posedge core_clk) disable iff (reset)
    state == ST_START && startup_done |=> !cpu_run [*4] ##1 wake_irq)
    else $error("wake halt not four cycles");
  a_pd_nowake: assert property (@(posedge core_clk) disable iff (reset)
    state == ST_SLEEP && mode == scd_pkg::SCD_SLP_PWRDOWN
    && !wake_sync.ext_irq && !wake_sync.addr_match |=> state != ST_START)
    else $error("illegal wake source");
  a_reg_decode: assert property (@(posedge core_clk) disable iff (reset)
    reg_rd && reg_data_space && reg_addr == 8'h5c
    |=> reg_rdata == $past(divide_control))
    else $error("data-space decode failed");

  c_div_on: cover property (@(posedge core_clk) wr_div && new_en && !div_en);
  c_sleep: cover property (@(posedge core_clk) state == ST_SLEEP);
  c_wake: cover property (@(posedge core_clk) wake_irq);
  c_trim_wr: cover property (@(posedge core_clk) wr_trim);

endmodule : scd_clock_ctrl

/* File: testbench/testbench.sv */
// Self-checking bench for scd_clock_ctrl: registers, divider, sleep gating.
// Assumes the block is alone on core_clk; the bench drives every input.
`timescale 1ns/1ps
module testbench;
  logic               core_clk, reset, reg_data_space, reg_wr, reg_rd;
  logic [7:0]         reg_addr, reg_wdata, reg_rdata, cal_byte_1mhz;
  logic               sleep_req, timer_async_select, crystal_selected;
  logic [2:0]         sleep_select_field;
  logic               startup_done, sys_tick, cpu_run, wake_irq;
  scd_pkg::scd_wake_s wake_raw;
  scd_pkg::scd_gate_s gate;
  logic [7:0]         trim_value_bits, v;
  logic [31:0]        r;
  logic [5:0]         m6;
  logic [2:0]         modes [8] = '{3'h0, 3'h1, 3'h2, 3'h3,
                                    3'h4, 3'h5, 3'h6, 3'h7};
  int                 bad_count, total_checks, seed;

  scd_clock_ctrl scd_clock_ctrl_i (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_data_space(reg_data_space), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .cal_byte_1mhz(cal_byte_1mhz), .sleep_req(sleep_req),
    .sleep_select_field(sleep_select_field),
    .timer_async_select(timer_async_select),
    .crystal_selected(crystal_selected), .startup_done(startup_done),
    .wake_raw(wake_raw), .gate(gate), .sys_tick(sys_tick),
    .cpu_run(cpu_run), .wake_irq(wake_irq),
    .trim_value_bits(trim_value_bits));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task check(input string name, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task give_up(input string name);
    check(name, 32'h0, 32'h1);
    stop_test();
  endtask : give_up

  // Inputs move 1 ns after the edge so sampling never races the driver
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task wr(input logic [7:0] off, input logic ds, input logic [7:0] d);
    reg_addr = ds ? off + 8'h20 : off;
    reg_data_space = ds;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask : wr

  task rd(input logic [7:0] off, input logic ds, output logic [7:0] d);
    reg_addr = ds ? off + 8'h20 : off;
    reg_data_space = ds;
    reg_rd = 1'b1;
    cyc(1);
    reg_rd = 1'b0;
    d = reg_rdata;
    cyc(1);
  endtask : rd

  // First period after a switch may be short, so the second one is kept
  task period(output logic [31:0] p);
    repeat (2) begin
      p = 0;
      do begin
        cyc(1);
        p++;
        if (p > 300) give_up("sys_tick");
      end while (sys_tick !== 1'b1);
    end
  endtask : period

  function logic [31:0] exp_div(input logic [6:0] d);
    return 32'd129 - {25'h0, d};
  endfunction : exp_div

  function logic [5:0] exp_gate(input logic [2:0] m, input logic a, x);
    case (m)
      3'h0, 3'h4, 3'h5: return 6'h0f;
      3'h1: return 6'h07;
      3'h3: return {4'h0, a, 1'b0};
      3'h6: return {5'h00, x};
      3'h7: return {4'h0, a, x};
      default: return 6'h00;
    endcase
  endfunction : exp_gate

  function logic [5:0] wake_mask(input logic [2:0] m, input logic a);
    case (m)
      3'h0, 3'h4, 3'h5: return 6'h3f;
      3'h1: return 6'h3e;
      3'h3, 3'h7: return {2'b11, a, 3'h0};
      default: return 6'h30;
    endcase
  endfunction : wake_mask

  initial begin
    repeat (60000) @(posedge core_clk);
    give_up("run_length");
  end

  initial begin
    seed = 32'h5938;
    {reset, reg_wr, reg_rd, reg_data_space, sleep_req} = 5'h10;
    {reg_addr, reg_wdata, sleep_select_field, startup_done} = '0;
    {timer_async_select, crystal_selected} = 2'b10;
    wake_raw = '0;
    cal_byte_1mhz = 8'($random(seed));
    cyc(6);
    reset = 1'b0;
    cyc(1);
    check("trim", trim_value_bits, cal_byte_1mhz);
    rd(8'h31, 1'b1, v); check("trim_rd", v, cal_byte_1mhz);
    rd(8'h32, 1'b0, v); check("unmapped", v, 8'h00);
    rd(8'h3c, 1'b0, v); check("divctl_rst", v, 8'h00);
    // No flash or EEPROM write runs here, so any trim is allowed
    repeat (4) begin
      r = $random(seed);
      wr(8'h31, r[8], r[7:0]);
      check("trim", trim_value_bits, r[7:0]);
      rd(8'h31, ~r[8], v); check("trim_rd", v, r[7:0]);
    end
    wr(8'h3c, 1'b0, 8'hff);
    period(r); check("period", r, 2);
    wr(8'h3c, 1'b1, 8'h80);
    period(r); check("period", r, 2);
    rd(8'h3c, 1'b1, v); check("divctl", v, 8'hff);
    wr(8'h3c, 1'b0, 8'h05);
    rd(8'h3c, 1'b0, v); check("divctl", v, 8'h7f);
    r = 0;
    repeat (8) begin
      cyc(1);
      if (sys_tick !== 1'b1) r++;
    end
    check("undivided", r, 0);
    wr(8'h3c, 1'b0, 8'h80);
    period(r); check("period", r, 129);
    repeat (3) begin
      wr(8'h3c, 1'b0, 8'h00);
      v = 8'($random(seed));
      wr(8'h3c, 1'b1, {1'b1, v[6:0]});
      period(r); check("period", r, exp_div(v[6:0]));
    end
    wr(8'h3c, 1'b0, 8'h00);
    for (int p = 0; p < 2; p++) begin
      foreach (modes[i]) begin
        sleep_select_field = modes[i];
        {timer_async_select, crystal_selected} = {p[0], p[0]};
        sleep_req = 1'b1;
        cyc(1);
        sleep_req = 1'b0;
        cyc(1);
        m6 = exp_gate(modes[i], p[0], p[0]);
        check("gate", {26'h0, gate}, {26'h0, m6});
        check("cpu_run", cpu_run, 0);
        wake_raw = scd_pkg::scd_wake_s'(~wake_mask(modes[i], p[0]));
        cyc(4);
        check("masked_wake", wake_irq, 0);
        check("gate", {26'h0, gate}, {26'h0, m6});
        wake_raw = scd_pkg::scd_wake_s'(6'h20);
        cyc(1);
        wake_raw = '0;
        startup_done = 1'b1;
        r = 0;
        while (wake_irq !== 1'b1) begin
          cyc(1);
          r++;
          if (r > 50) give_up("wake_irq");
        end
        // Second sync flop, the wake edge, the start-up edge, then the four halt cycles
        check("wake_delay", r, scd_pkg::WAKE_HALT_CYC + 3);
        check("gate", {26'h0, gate}, 32'h3f);
        cyc(1);
        check("wake_pulse", wake_irq, 0);
        check("cpu_run", cpu_run, 1);
        startup_done = 1'b0;
      end
    end
    stop_test();
  end
endmodule : testbench
